// [design/card_cmd_defines.vh]
// constants for the card command and status handler
//
// Behaviour
// - unblock: class a0, ins 2c, p1 00, p2 01, lc 10; unblock then new code
// - challenge-response: a0 88 00 00, 8-byte challenge gives 8-byte cryptogram
// - get response: a0 c0 00 00, le bytes of the previous command's data; here always crypt_byte bytes from the key engine
// - only challenge, seek type 2, select, get response leave data; here get response clears pending data
// - get response not straight after its command answers 6f
// - access conditions are reported in select response byte 9
// - access nibble: 0 always, 1 after verification, f never
// - for the application directory bit 8 of access info is 0
// - unblock code is exactly 8 digits, no padding
// - two status bytes follow every command
// - 98 02 when the needed code or key is undefined
// - 98 04 access unmet or failed verification with attempts left
// - 3 consecutive code failures block code, 98 40 thereafter
// - 10 consecutive unblock failures block unblocking, 98 40 thereafter
// - 98 08 contradicts code state, 98 10 contradicts invalidation state
// - 94 00 no file, 94 02 out of range, 94 04 not found
// - 94 08 when file structure does not suit the command
// - 6e bad class, 6d unknown instruction
// - 6b bad p1 or p2
// - 67 wrong length
// - 90 00 on normal end with no data pending
// - 9f and data length when data awaits get response
`ifndef CARD_CMD_DEFINES_VH
`define CARD_CMD_DEFINES_VH
`define CLA_CARD      8'ha0
`define INS_VERIFY    8'h20
`define INS_CHANGE    8'h24
`define INS_UNBLOCK   8'h2c
`define INS_CHALLENGE 8'h88
`define INS_GETRESP   8'hc0
`define INS_SELECT    8'ha4
`define INS_SEEK      8'ha2
`define INS_RD_BIN    8'hb0
`define INS_WR_BIN    8'hd6
`define INS_RD_REC    8'hb2
`define INS_WR_REC    8'hdc
`define P_ZERO        8'h00
`define P2_PRIMARY    8'h01
`define LC_CODE       8'h08
`define LC_UNBLOCK    8'h10
`define LC_CHALLENGE  8'h08
`define CRYPT_LEN     8'h08
`define SEEK_TYPE2    4'h1
`define SW1_OK        8'h90
`define SW1_DATA      8'h9f
`define SW1_SEC       8'h98
`define SW1_REF       8'h94
`define SW1_CLASS     8'h6e
`define SW1_INS       8'h6d
`define SW1_TECH      8'h6f
`define SW1_PARAM     8'h6b
`define SW1_LEN       8'h67
`define SW2_ZERO      8'h00
`define SW2_UNDEF     8'h02
`define SW2_ACFAIL    8'h04
`define SW2_CHVSTATE  8'h08
`define SW2_INVAL     8'h10
`define SW2_BLOCKED   8'h40
`define SW2_ADDR      8'h02
`define SW2_NOTFOUND  8'h04
`define SW2_FTYPE     8'h08
`define CODE_PRESET   4'h3
`define UNBLK_PRESET  4'ha
`define AC_ALWAYS     4'h0
`define AC_CODE       4'h1
`define AC_NEVER      4'hf
`define ASCII_ZERO    8'h30
`define ASCII_NINE    8'h39
`define PAD_BYTE      8'hff
`define MIN_DIGITS    4'h4
`endif

// [design/card_command_status_handler.v]
// command decoder, secret-code checker and status generator of the card
`timescale 1ns/10ps
`default_nettype none
`include "card_cmd_defines.vh"
module card_command_status_handler #(
    parameter DATA_BYTES = 16
) (
    input  wire        clk,           // 20 MHz card clock
    input  wire        rst,           // async, active high
    input  wire        hdr_valid,     // header bytes present (pulse)
    input  wire [7:0]  cla,           // class byte
    input  wire [7:0]  ins,           // instruction byte
    input  wire [7:0]  p1,            // parameter 1
    input  wire [7:0]  p2,            // parameter 2
    input  wire [7:0]  p3,            // lc or le
    input  wire        data_valid,    // one command data byte (pulse)
    input  wire [7:0]  data_byte,     // command data byte
    input  wire        file_status_valid, // file logic answer for select, seek, read and write commands (pulse)
    input  wire [7:0]  file_sw1,      // file logic status byte 1
    input  wire [7:0]  file_sw2,      // file logic status byte 2
    input  wire [7:0]  file_resp_len, // file logic response length
    input  wire [7:0]  crypt_byte,    // cryptogram byte from key engine
    input  wire        code_defined,  // a secret code is defined
    input  wire        dir_selected,  // application directory is current
    input  wire [3:0]  file_ac,       // access nibble of current file
    output reg         file_cmd,      // command passed to file logic (pulse)
    output reg  [7:0]  access_byte,   // byte 9 of select response
    output reg         code_verified, // primary code verified (level)
    output reg         code_blocked,  // primary code blocked (level)
    output reg         unblock_blocked, // unblock mechanism blocked (level)
    output reg  [3:0]  code_tries,    // remaining code attempts
    output reg  [3:0]  unblock_tries, // remaining unblock attempts
    output reg  [7:0]  resp_byte,     // response data byte
    output reg         resp_valid,    // response data byte strobe
    output reg  [7:0]  sw1,           // status byte 1
    output reg  [7:0]  sw2,           // status byte 2
    output reg         sw_valid       // status pair strobe (pulse)
);
    localparam S_IDLE  = 5'b00001;
    localparam S_DATA  = 5'b00010;
    localparam S_EXEC  = 5'b00100;
    localparam S_FILE  = 5'b01000;
    localparam S_SEND  = 5'b10000;

    reg [4:0]  state;
    reg [7:0]  cur_ins;
    reg [7:0]  cur_p2;
    reg [7:0]  cur_len;
    reg [7:0]  cnt;
    reg [7:0]  buf_mem [0:DATA_BYTES-1];
    reg [7:0]  pend_len;
    reg        pend_ok;
    reg [7:0]  code_mem [0:7];
    reg [7:0]  unblk_mem [0:7];
    reg        digits_ok;
    reg        code_match;
    reg        unblk_match;
    reg [3:0]  new_digits;
    reg        pad_seen;
    integer    i;
    integer    j;

    function digit;
        input [7:0] b;
        begin
            digit = (b >= `ASCII_ZERO) && (b <= `ASCII_NINE);
        end
    endfunction

    function [15:0] status;
        input [7:0] a;
        input [7:0] b;
        begin
            status = {a, b};
        end
    endfunction

    // header check in fixed order; 0 means header accepted
    reg [15:0] hdr_err;
    always @* begin
        hdr_err = 16'h0000;
        if (cla != `CLA_CARD) begin
            hdr_err = status(`SW1_CLASS, `SW2_ZERO);
        end else begin
            case (ins)
                `INS_VERIFY, `INS_CHANGE, `INS_UNBLOCK: begin
                    if (p1 != `P_ZERO || p2 != `P2_PRIMARY)
                        hdr_err = status(`SW1_PARAM, `SW2_ZERO);
                    else if (p3 != ((ins == `INS_VERIFY) ? `LC_CODE : `LC_UNBLOCK))
                        hdr_err = status(`SW1_LEN, `SW2_ZERO);
                end

                `INS_CHALLENGE: begin
                    if (p1 != `P_ZERO || p2 != `P_ZERO)
                        hdr_err = status(`SW1_PARAM, `SW2_ZERO);
                    else if (p3 != `LC_CHALLENGE)
                        hdr_err = status(`SW1_LEN, `SW2_ZERO);
                end

                `INS_GETRESP: begin
                    if (p1 != `P_ZERO || p2 != `P_ZERO)
                        hdr_err = status(`SW1_PARAM, `SW2_ZERO);
                    else if (!pend_ok)
                        hdr_err = status(`SW1_TECH, `SW2_ZERO);
                    else if (p3 == `P_ZERO || p3 > pend_len)
                        hdr_err = status(`SW1_LEN, pend_len);
                end

                `INS_SELECT, `INS_SEEK, `INS_RD_BIN, `INS_WR_BIN,
                `INS_RD_REC, `INS_WR_REC:
                    hdr_err = 16'h0000;

                default:
                    hdr_err = status(`SW1_INS, `SW2_ZERO);
            endcase
        end
    end

    // digit coding check and comparisons over the received bytes
    always @* begin
        digits_ok = 1'b1;
        code_match = 1'b1;
        unblk_match = 1'b1;
        new_digits = 4'h0;
        pad_seen = 1'b0;
        for (j = 0; j < 8; j = j + 1) begin
            if (cur_ins == `INS_UNBLOCK) begin
                if (!digit(buf_mem[j]))
                    digits_ok = 1'b0;
                if (buf_mem[j] != unblk_mem[j])
                    unblk_match = 1'b0;
                // a digit after padding leaves a gap in the code
                if (digit(buf_mem[j+8]) && !pad_seen)
                    new_digits = new_digits + 4'h1;
                else if (buf_mem[j+8] == `PAD_BYTE)
                    pad_seen = 1'b1;
                else
                    digits_ok = 1'b0;
            end else begin
                if (buf_mem[j] != code_mem[j])
                    code_match = 1'b0;
            end
        end
        if (cur_ins == `INS_UNBLOCK && new_digits < `MIN_DIGITS)
            digits_ok = 1'b0;
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            cur_ins <= 8'h00;
            cur_p2 <= 8'h00;
            cur_len <= 8'h00;
            cnt <= 8'h00;
            pend_len <= 8'h00;
            pend_ok <= 1'b0;
            file_cmd <= 1'b0;
            access_byte <= 8'h00;
            code_verified <= 1'b0;
            code_blocked <= 1'b0;
            unblock_blocked <= 1'b0;
            code_tries <= `CODE_PRESET;
            unblock_tries <= `UNBLK_PRESET;
            resp_byte <= 8'h00;
            resp_valid <= 1'b0;
            sw1 <= 8'h00;
            sw2 <= 8'h00;
            sw_valid <= 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
                code_mem[i] <= 8'h00;
                unblk_mem[i] <= 8'h00;
            end
            for (i = 0; i < DATA_BYTES; i = i + 1)
                buf_mem[i] <= 8'h00;
        end else begin
            sw_valid <= 1'b0;
            resp_valid <= 1'b0;
            file_cmd <= 1'b0;
            case (state)
                S_IDLE: if (hdr_valid) begin
                    cur_ins <= ins;
                    cur_p2 <= p2;
                    cur_len <= p3;
                    cnt <= 8'h00;
                    // any command other than get response drops pending data
                    if (ins != `INS_GETRESP)
                        pend_ok <= 1'b0;
                    if (hdr_err != 16'h0000) begin
                        {sw1, sw2} <= hdr_err;
                        sw_valid <= 1'b1;
                        pend_ok <= 1'b0;
                    end else if (ins == `INS_GETRESP) begin
                        state <= S_SEND;
                    end else if (ins == `INS_VERIFY || ins == `INS_CHANGE
                                 || ins == `INS_UNBLOCK || ins == `INS_CHALLENGE) begin
                        state <= S_DATA;
                    end else begin
                        file_cmd <= 1'b1;
                        state <= S_FILE;
                    end
                end

                S_DATA: if (data_valid) begin
                    buf_mem[cnt[3:0]] <= data_byte;
                    cnt <= cnt + 8'h01;
                    if (cnt + 8'h01 == cur_len)
                        state <= S_EXEC;
                end

                S_EXEC: begin
                    state <= S_IDLE;
                    sw_valid <= 1'b1;
                    {sw1, sw2} <= status(`SW1_OK, `SW2_ZERO);
                    if (cur_ins == `INS_CHALLENGE) begin
                        if (!code_defined)
                            {sw1, sw2} <= status(`SW1_SEC, `SW2_UNDEF);
                        else if (file_ac == `AC_NEVER
                                 || (file_ac == `AC_CODE && !code_verified))
                            {sw1, sw2} <= status(`SW1_SEC, `SW2_ACFAIL);
                        else begin
                            pend_len <= `CRYPT_LEN;
                            pend_ok <= 1'b1;
                            {sw1, sw2} <= status(`SW1_DATA, `CRYPT_LEN);
                        end
                    end else if (!code_defined) begin
                        {sw1, sw2} <= status(`SW1_SEC, `SW2_UNDEF);
                    end else if (cur_ins == `INS_UNBLOCK) begin
                        if (unblock_blocked)
                            {sw1, sw2} <= status(`SW1_SEC, `SW2_BLOCKED);
                        else if (!digits_ok)
                            {sw1, sw2} <= status(`SW1_SEC, `SW2_CHVSTATE);
                        else if (unblk_match) begin
                            unblock_tries <= `UNBLK_PRESET;
                            code_tries <= `CODE_PRESET;
                            code_blocked <= 1'b0;
                            code_verified <= 1'b1;
                            for (i = 0; i < 8; i = i + 1)
                                code_mem[i] <= buf_mem[i+8];
                        end else begin
                            // decrement in the same cycle as reporting so power loss cannot skip it
                            unblock_tries <= unblock_tries - 4'h1;
                            if (unblock_tries == 4'h1) begin
                                unblock_blocked <= 1'b1;
                                {sw1, sw2} <= status(`SW1_SEC, `SW2_BLOCKED);
                            end else
                                {sw1, sw2} <= status(`SW1_SEC, `SW2_ACFAIL);
                        end
                    end else begin
                        if (code_blocked)
                            {sw1, sw2} <= status(`SW1_SEC, `SW2_BLOCKED);
                        else if (code_match) begin
                            code_tries <= `CODE_PRESET;
                            code_verified <= 1'b1;
                            if (cur_ins == `INS_CHANGE)
                                for (i = 0; i < 8; i = i + 1)
                                    code_mem[i] <= buf_mem[i+8];
                        end else begin
                            code_tries <= code_tries - 4'h1;
                            code_verified <= 1'b0;
                            if (code_tries == 4'h1) begin
                                code_blocked <= 1'b1;
                                {sw1, sw2} <= status(`SW1_SEC, `SW2_BLOCKED);
                            end else
                                {sw1, sw2} <= status(`SW1_SEC, `SW2_ACFAIL);
                        end
                    end
                end

                S_FILE: if (file_status_valid) begin
                    state <= S_IDLE;
                    sw_valid <= 1'b1;
                    // bit 8 cleared for the directory, low nibble is access rule
                    access_byte <= {~dir_selected & file_ac[3], 3'b000,
                                    file_ac};
                    if ((cur_ins == `INS_SELECT || (cur_ins == `INS_SEEK
                         && cur_p2[7:4] == `SEEK_TYPE2)) && file_sw1 == `SW1_OK
                         && file_resp_len != 8'h00) begin
                        pend_len <= file_resp_len;
                        pend_ok <= 1'b1;
                        {sw1, sw2} <= status(`SW1_DATA, file_resp_len);
                    end else
                        {sw1, sw2} <= {file_sw1, file_sw2};
                end

                S_SEND: begin
                    resp_byte <= crypt_byte;
                    resp_valid <= 1'b1;
                    cnt <= cnt + 8'h01;
                    if (cnt + 8'h01 == cur_len) begin
                        state <= S_IDLE;
                        sw_valid <= 1'b1;
                        pend_ok <= 1'b0;
                        {sw1, sw2} <= status(`SW1_OK, `SW2_ZERO);
                    end
                end

                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // card_command_status_handler
`default_nettype wire

// [tb/card_status_properties.sv]
// port assertions for the card command and status handler
`timescale 1ns/10ps
`default_nettype none
module card_status_checker (
    input wire logic       clk,             // card clock
    input wire logic       rst,             // async reset
    input wire logic       hdr_valid,       // header strobe
    input wire logic [7:0] cla,             // class byte
    input wire logic [7:0] ins,             // instruction
    input wire logic [7:0] p1,              // parameter 1
    input wire logic [7:0] p2,              // parameter 2
    input wire logic [7:0] p3,              // length byte
    input wire logic       resp_valid,      // response strobe
    input wire logic       code_blocked,    // code blocked
    input wire logic       unblock_blocked, // unblock blocked
    input wire logic [3:0] code_tries,      // code tries left
    input wire logic [3:0] unblock_tries,   // unblock tries left
    input wire logic [7:0] sw1,             // status byte 1
    input wire logic       sw_valid         // status strobe
);
    logic busy;
    logic pend;
    wire  take = hdr_valid && !busy;
    // headers arriving while busy are ignored, so only count ones taken idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            pend <= 1'b0;
        end else if (sw_valid) begin
            busy <= 1'b0;
            pend <= (sw1 == 8'h9f);
        end else if (take) begin
            busy <= 1'b1;
            pend <= 1'b0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    bad_class_a:
        assert property (take && cla != 8'ha0 |=> sw_valid && sw1 == 8'h6e)
        else $error("class fault not reported");
    unknown_ins_a:
        assert property (take && cla == 8'ha0 && !(ins inside {8'h20, 8'h24, 8'h2c, 8'h88,
            8'hc0, 8'ha4, 8'ha2, 8'hb0, 8'hd6, 8'hb2, 8'hdc}) |=> sw_valid && sw1 == 8'h6d)
        else $error("unknown instruction not reported");
    bad_param_a:
        assert property (take && cla == 8'ha0 && ins == 8'h20 && (p1 != 8'h00 || p2 != 8'h01)
            |=> sw_valid && sw1 == 8'h6b)
        else $error("parameter fault not reported");
    bad_length_a:
        assert property (take && cla == 8'ha0 && ins == 8'h20 && p1 == 8'h00 && p2 == 8'h01
            && p3 != 8'h08 |=> sw_valid && sw1 == 8'h67)
        else $error("length fault not reported");
    fetch_order_a:
        assert property (take && cla == 8'ha0 && ins == 8'hc0 && p1 == 8'h00 && p2 == 8'h00
            && p3 != 8'h00 && !pend |=> sw_valid && sw1 == 8'h6f)
        else $error("stray fetch not refused");
    resp_last_a:
        assert property ($fell(resp_valid) |-> $past(sw_valid))
        else $error("status not with last response byte");
    status_pulse_a:
        assert property (sw_valid |=> !sw_valid)
        else $error("status strobe longer than a cycle");
    code_block_a:
        assert property (sw_valid |-> code_blocked == (code_tries == 4'h0))
        else $error("code block flag disagrees with tries");
    unblock_block_a:
        assert property (sw_valid |-> unblock_blocked == (unblock_tries == 4'h0))
        else $error("unblock flag disagrees with tries");
    tries_range_a:
        assert property (code_tries <= 4'h3 && unblock_tries <= 4'ha)
        else $error("tries above preset");
endmodule // card_status_checker
bind card_command_status_handler card_status_checker card_status_checker_inst (
    .clk(clk), .rst(rst), .hdr_valid(hdr_valid), .cla(cla), .ins(ins), .p1(p1), .p2(p2),
    .p3(p3), .resp_valid(resp_valid), .code_blocked(code_blocked),
    .unblock_blocked(unblock_blocked), .code_tries(code_tries),
    .unblock_tries(unblock_tries), .sw1(sw1), .sw_valid(sw_valid)
);
`default_nettype wire

// [tb/file_logic_model.sv]
// file logic and key engine model answering the handler
`timescale 1ns/10ps
`default_nettype none
module file_logic_model (
    input  wire logic       clk,               // card clock
    input  wire logic       rst,               // async reset
    input  wire logic       file_cmd,          // request strobe
    input  wire logic       slow,              // answer late
    input  wire logic [23:0] ans,              // sw1, sw2, length to give
    output logic            file_status_valid, // answer strobe
    output logic      [7:0] file_sw1,          // status 1
    output logic      [7:0] file_sw2,          // status 2
    output logic      [7:0] file_resp_len,     // data length
    output logic      [7:0] crypt_byte         // cryptogram stream
);
    logic [3:0] wait_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 4'h0;
            file_status_valid <= 1'b0;
            {file_sw1, file_sw2, file_resp_len, crypt_byte} <= 32'h0;
        end else begin
            file_status_valid <= 1'b0;
            crypt_byte <= crypt_byte + 8'h1;
            if (file_cmd)
                wait_cnt <= slow ? 4'h6 : 4'h1;
            else if (wait_cnt != 4'h0)
                wait_cnt <= wait_cnt - 4'h1;
            if (wait_cnt == 4'h1) begin
                file_status_valid <= 1'b1;
                {file_sw1, file_sw2, file_resp_len} <= ans;
            end else begin
                // toggling outside the answer so a stale sample shows up
                {file_sw1, file_sw2, file_resp_len} <= ~{file_sw1, file_sw2, file_resp_len};
            end
        end
    end
endmodule // file_logic_model
`default_nettype wire

// [tb/card_command_status_handler_bench.sv]
// self-checking bench for the card command and status handler
`timescale 1ns/10ps
`default_nettype none
module card_command_status_handler_bench;
    logic        clk = 1'b0, rst = 1'b1, hdr_valid = 1'b0, data_valid = 1'b0;
    logic        code_defined = 1'b1, dir_selected = 1'b0, slow = 1'b0;
    logic [3:0]  file_ac = 4'h1;
    logic [7:0]  cla = 8'h0, ins = 8'h0, p1 = 8'h0, p2 = 8'h0, p3 = 8'h0, data_byte = 8'h0;
    logic [7:0]  dq [16];
    logic [23:0] ans = 24'h900000;
    logic [31:0] seed = 32'h28485a6b;
    wire         file_cmd, code_verified, code_blocked, unblock_blocked, resp_valid, sw_valid;
    wire         file_status_valid;
    wire  [3:0]  code_tries, unblock_tries;
    wire  [7:0]  access_byte, resp_byte, sw1, sw2, file_sw1, file_sw2, file_resp_len, crypt_byte;
    int          n_mismatch = 0, n_compared = 0, nr, nf, i;
    logic [47:0] htab [7] = '{48'ha0_00_ff_ff_08_6d, 48'ha0_20_01_01_08_6b,
        48'ha0_2c_00_02_10_6b, 48'ha0_20_00_01_09_67, 48'ha0_2c_00_01_08_67,
        48'ha0_88_00_00_07_67, 48'ha0_c0_01_00_08_6b};
    logic [39:0] ftab [10] = '{40'ha4_00_90_00_14, 40'ha2_10_90_00_01, 40'ha2_00_90_00_01,
        40'hb0_00_94_00_00, 40'hb2_04_94_02_00, 40'ha2_10_94_04_00, 40'hdc_04_94_08_00,
        40'hd6_00_98_10_00, 40'ha4_00_90_00_17, 40'hb0_00_98_04_00};
    card_command_status_handler #(.DATA_BYTES(16)) card_command_status_handler_inst (
        .clk(clk), .rst(rst), .hdr_valid(hdr_valid), .cla(cla), .ins(ins), .p1(p1), .p2(p2),
        .p3(p3), .data_valid(data_valid), .data_byte(data_byte),
        .file_status_valid(file_status_valid), .file_sw1(file_sw1), .file_sw2(file_sw2),
        .file_resp_len(file_resp_len), .crypt_byte(crypt_byte), .code_defined(code_defined),
        .dir_selected(dir_selected), .file_ac(file_ac), .file_cmd(file_cmd),
        .access_byte(access_byte), .code_verified(code_verified), .code_blocked(code_blocked),
        .unblock_blocked(unblock_blocked), .code_tries(code_tries),
        .unblock_tries(unblock_tries), .resp_byte(resp_byte), .resp_valid(resp_valid),
        .sw1(sw1), .sw2(sw2), .sw_valid(sw_valid));
    file_logic_model file_logic_model_inst (.clk(clk), .rst(rst), .file_cmd(file_cmd),
        .slow(slow), .ans(ans), .file_status_valid(file_status_valid), .file_sw1(file_sw1),
        .file_sw2(file_sw2), .file_resp_len(file_resp_len), .crypt_byte(crypt_byte));
    always #25 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [23:0] exp_sec(input int f, lim);
        return (f < lim) ? {16'h9804, 4'h0, 4'(lim - f)} : 24'h984000;
    endfunction
    // only select and type-2 seek turn a clean file answer into pending data
    function automatic logic [15:0] exp_file(input logic [7:0] n, b, input logic [23:0] st);
        if (st[23:16] == 8'h90 && st[7:0] != 8'h0
            && (n == 8'ha4 || (n == 8'ha2 && b[7:4] == 4'h1)))
            return {8'h9f, st[7:0]};
        return st[23:8];
    endfunction
    task automatic check(input logic [23:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk) #2;
    endtask
    task automatic fill(input int from, nd);
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            dq[from + k] = (k < nd) ? 8'h30 + seed[7:0] % 8'd10 : 8'hff;
        end
    endtask
    task automatic cmd(input logic [7:0] c, n, a, b, l, input int nd);
        int k;
        logic [7:0] rb;
        tick();
        hdr_valid = 1'b1;
        {cla, ins, p1, p2, p3} = {c, n, a, b, l};
        for (k = 0; k < nd; k++) begin
            tick();
            hdr_valid = 1'b0;
            data_valid = 1'b1;
            data_byte = dq[k];
        end
        tick();
        hdr_valid = 1'b0;
        data_valid = 1'b0;
        nr = 0;
        nf = 0;
        for (k = 0; k < 300; k++) begin
            @(negedge clk);
            nr += int'(resp_valid === 1'b1);
            nf += int'(file_cmd === 1'b1);
            if (resp_valid === 1'b1 && nr > 1)
                check({16'h0, resp_byte - rb}, 24'h1);
            rb = resp_byte;
            if (sw_valid === 1'b1) break;
        end
        check({23'h0, sw_valid}, 24'h1);
    endtask
    task stop_test();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        #2 rst = 1'b0;
        check({4'h0, code_tries, 12'h0, unblock_tries}, 24'h03000a);
        for (i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            if (seed[7:0] == 8'ha0) seed[0] = 1'b1;
            cmd(seed[7:0], seed[15:8], seed[23:16], seed[31:24], 8'h08, 0);
            check({sw1, 16'h0}, 24'h6e0000);
        end
        for (i = 0; i < 7; i++) begin
            cmd(htab[i][47:40], htab[i][39:32], htab[i][31:24], htab[i][23:16], htab[i][15:8], 0);
            check({sw1, 16'h0}, {htab[i][7:0], 16'h0});
        end
        fill(0, 6);
        tick();
        code_defined = 1'b0;
        cmd(8'ha0, 8'h20, 8'h00, 8'h01, 8'h08, 8);
        check({sw1, sw2, 4'h0, code_tries}, 24'h980203);
        tick();
        code_defined = 1'b1;
        cmd(8'ha0, 8'h88, 8'h00, 8'h00, 8'h08, 8);
        check({sw1, sw2, 8'h0}, 24'h980400);
        tick();
        file_ac = 4'h0;
        cmd(8'ha0, 8'h88, 8'h00, 8'h00, 8'h08, 8);
        check({sw1, sw2, 8'h0}, 24'h9f0800);
        cmd(8'ha0, 8'hc0, 8'h00, 8'h00, 8'h08, 0);
        check({sw1, sw2, nr[7:0]}, 24'h900008);
        cmd(8'ha0, 8'hc0, 8'h00, 8'h00, 8'h08, 0);
        check({sw1, 16'h0}, 24'h6f0000);
        cmd(8'ha0, 8'h88, 8'h00, 8'h00, 8'h08, 8);
        cmd(8'ha0, 8'hc0, 8'h00, 8'h00, 8'h09, 0);
        check({sw1, 16'h0}, 24'h670000);
        cmd(8'ha0, 8'h88, 8'h00, 8'h00, 8'h08, 8);
        cmd(8'h00, 8'h20, 8'h00, 8'h01, 8'h08, 0);
        cmd(8'ha0, 8'hc0, 8'h00, 8'h00, 8'h08, 0);
        check({sw1, 16'h0}, 24'h6f0000);
        for (i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            tick();
            ans = ftab[i][23:0];
            slow = i[0];
            dir_selected = seed[0];
            file_ac = seed[1] ? 4'hf : {3'h0, seed[2]};
            cmd(8'ha0, ftab[i][39:32], 8'h00, ftab[i][31:24], 8'h02, 0);
            check({sw1, sw2, nf[7:0]},
                  {exp_file(ftab[i][39:32], ftab[i][31:24], ans), 8'h1});
            if (ftab[i][39:32] == 8'ha4)
                check({16'h0, access_byte},
                      {16'h0, seed[1] & ~seed[0], 3'h0, file_ac});
        end
        for (i = 0; i < 4; i++) begin
            fill(0, 4 + i);
            cmd(8'ha0, 8'h20, 8'h00, 8'h01, 8'h08, 8);
            check({sw1, sw2, 3'h0, code_verified, code_tries}, exp_sec(i + 1, 3));
        end
        fill(0, 8);
        fill(8, 3);
        cmd(8'ha0, 8'h2c, 8'h00, 8'h01, 8'h10, 16);
        check({sw1, sw2, 4'h0, unblock_tries}, 24'h98080a);
        for (i = 0; i < 11; i++) begin
            fill(0, 8);
            fill(8, 8);
            cmd(8'ha0, 8'h2c, 8'h00, 8'h01, 8'h10, 16);
            check({sw1, sw2, 4'h0, unblock_tries}, exp_sec(i + 1, 10));
        end
        cmd(8'ha0, 8'h24, 8'h00, 8'h01, 8'h10, 16);
        check({sw1, sw2, 4'h0, code_tries}, 24'h984000);
        stop_test();
    end
endmodule // card_command_status_handler_bench
`default_nettype wire
